//--- hdl/csb_computer.sv
/*
 computer end: phase generator, break request sync, break cycle, core memory.
 assumes the device keeps its request, address, direction and data stable.
*/
`timescale 1ns/1ps
module csb_computer
	import csb_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	csb_if.computer LINK,
	output logic BREAK_ACTIVE,
	output logic [14:0] LAST_ADDRESS
);
	// ----------------------------------------
	// timing phases
	// ----------------------------------------
	logic [3:0] tick_r;
	csb_phase_t phase_r;
	csb_phase_t phase_nxt;
	logic phase_end;
	logic cycle_end;
	logic delayed_phase_five;
	assign phase_end = (tick_r == CSB_PHASE_CLKS - 4'h1);
	assign cycle_end = phase_end && (phase_r == CSB_T5);
	// late in T5, so request and address have settled
	assign delayed_phase_five = cycle_end;
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			tick_r <= CSB_PHASE_RST;
		else if (phase_end)
			tick_r <= CSB_PHASE_RST;
		else
			tick_r <= tick_r + 4'h1;
	end
	// fixed ring of phases; T5 wraps to T1 to open the next cycle
	always_comb
	begin
		phase_nxt = CSB_T1;
		case (phase_r)
			CSB_T1: phase_nxt = CSB_T2;
			CSB_T2: phase_nxt = CSB_T3;
			CSB_T3: phase_nxt = CSB_T4;
			CSB_T4: phase_nxt = CSB_T5;
			CSB_T5: phase_nxt = CSB_T1;
			default: phase_nxt = CSB_T1;
		endcase
	end
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			phase_r <= CSB_T1;
		else if (phase_end)
			phase_r <= phase_nxt;
	end
	// ----------------------------------------
	// request sync and major state
	// ----------------------------------------
	logic data_sync_r;
	logic break_state_r;
	logic [1:0] instr_cnt_r;
	logic break_request_level;
	logic qualified_break;
	logic phase_start;
	logic instr_last;
	logic enter_break;
	assign phase_start = (tick_r == CSB_PHASE_RST);
	// looked at once a cycle: a request shorter than a cycle can be missed
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			data_sync_r <= 1'b0;
		else if (delayed_phase_five)
			data_sync_r <= LINK.transfer_request_level;
	end
	assign break_request_level = data_sync_r;
	// instruction counter: a break waits for the running instruction to end
	assign instr_last = (instr_cnt_r == CSB_INSTR_CYCLES - 2'h1);
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			instr_cnt_r <= 2'h0;
		else if (cycle_end && !break_state_r)
			instr_cnt_r <= instr_last ? 2'h0 : instr_cnt_r + 2'h1;
	end
	// a fresh sync at this same edge is seen next cycle end
	assign enter_break = break_request_level && instr_last;
	// once the request drops, the state lingers one cycle with no pulses
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			break_state_r <= 1'b0;
		else if (cycle_end)
		begin
			if (break_state_r)
				break_state_r <= break_request_level;
			else
				break_state_r <= enter_break;
		end
	end
	assign qualified_break = break_state_r && data_sync_r;
	// ----------------------------------------
	// break-cycle pulses and buffer
	// ----------------------------------------
	logic [17:0] core_mem [CSB_MEM_WORDS];
	logic [14:0] memory_address_reg;
	logic [17:0] memory_buffer_reg;
	logic t1_start;
	logic t2_start;
	logic t3_start;
	logic t5_start;
	logic addr_pulse_nxt;
	logic data_accepted_pulse_nxt;
	logic data_rdy_nxt;
	logic read_nxt;
	logic write_nxt;
	// pulses fire on the first clock of a phase, so each stands one clock
	assign t1_start = phase_start && (phase_r == CSB_T1);
	assign t2_start = phase_start && (phase_r == CSB_T2);
	assign t3_start = phase_start && (phase_r == CSB_T3);
	assign t5_start = phase_start && (phase_r == CSB_T5);
	// direction is read live, so the device must hold it through the cycle
	assign addr_pulse_nxt = qualified_break && t1_start;
	assign data_accepted_pulse_nxt = qualified_break && t3_start && LINK.dir_into_memory;
	assign data_rdy_nxt = qualified_break && t3_start && !LINK.dir_into_memory;
	// outward read fetches into the buffer at T2, ahead of data ready at T3
	assign read_nxt = qualified_break && t2_start && !LINK.dir_into_memory;
	assign write_nxt = qualified_break && t5_start && LINK.dir_into_memory;
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			memory_address_reg <= CSB_ADDR_RST;
		else if (addr_pulse_nxt)
			memory_address_reg <= LINK.break_address_lines;
	end
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			memory_buffer_reg <= CSB_DATA_RST;
		else if (data_accepted_pulse_nxt)
			memory_buffer_reg <= LINK.inbound_data_lines;
		else if (read_nxt)
			memory_buffer_reg <= core_mem[memory_address_reg];
	end
	// ----------------------------------------
	// core memory
	// ----------------------------------------
	// core array has no reset: it is memory, not control state
	always_ff @(posedge CLK)
	begin
		if (write_nxt)
			core_mem[memory_address_reg] <= memory_buffer_reg;
	end
	// ----------------------------------------
	// link and status outputs
	// ----------------------------------------
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			LINK.address_accepted_pulse <= 1'b0;
			LINK.data_accepted_pulse <= 1'b0;
			LINK.data_ready_pulse <= 1'b0;
		end
		else
		begin
			LINK.address_accepted_pulse <= addr_pulse_nxt;
			LINK.data_accepted_pulse <= data_accepted_pulse_nxt;
			LINK.data_ready_pulse <= data_rdy_nxt;
		end
	end
	// the word lags the buffer by a clock yet settles well before data ready
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			LINK.buffered_memory_out <= CSB_DATA_RST;
		else
			LINK.buffered_memory_out <= memory_buffer_reg;
	end
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			BREAK_ACTIVE <= 1'b0;
		else
			BREAK_ACTIVE <= qualified_break;
	end
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			LAST_ADDRESS <= CSB_ADDR_RST;
		else
			LAST_ADDRESS <= memory_address_reg;
	end
endmodule // csb_computer

//--- hdl/csb_pkg.sv
/*
 cycle-steal break channel: shared constants and types.
 assumes one 50 MHz clock shared by both ends.
*/
package csb_pkg;
	localparam int CSB_ADDR_W = 15;
	localparam int CSB_DATA_W = 18;
	localparam int CSB_MEM_WORDS = 32768;
	// each timing phase lasts this many clocks; five phases make a machine cycle
	localparam logic [3:0] CSB_PHASE_CLKS = 4'h4;
	localparam logic [3:0] CSB_PHASE_RST = 4'h0;
	// instruction cycles before the major state may enter break
	localparam logic [1:0] CSB_INSTR_CYCLES = 2'h2;
	localparam logic [14:0] CSB_ADDR_RST = 15'h0000;
	localparam logic [17:0] CSB_DATA_RST = 18'h00000;
	typedef enum logic [2:0] {CSB_T1, CSB_T2, CSB_T3, CSB_T4, CSB_T5} csb_phase_t;
	typedef enum {CSB_HS_IDLE, CSB_HS_WAIT, CSB_HS_DONE} csb_hs_t;
endpackage

//--- hdl/csb_if.sv
/*
 link between the computer end and the device end of the break channel.
 assumes both ends run on the same clock; levels are active high here.
*/
`timescale 1ns/1ps
interface csb_if;
	logic transfer_request_level;
	logic dir_into_memory;
	logic [14:0] break_address_lines;
	logic [17:0] inbound_data_lines;
	logic address_accepted_pulse;
	logic data_accepted_pulse;
	logic data_ready_pulse;
	logic [17:0] buffered_memory_out;
	modport computer (
		input transfer_request_level,
		input dir_into_memory,
		input break_address_lines,
		input inbound_data_lines,
		output address_accepted_pulse,
		output data_accepted_pulse,
		output data_ready_pulse,
		output buffered_memory_out
	);
	modport device (
		output transfer_request_level,
		output dir_into_memory,
		output break_address_lines,
		output inbound_data_lines,
		input address_accepted_pulse,
		input data_accepted_pulse,
		input data_ready_pulse,
		input buffered_memory_out
	);
endinterface

//--- hdl/csb_device.sv
/*
 device end: takes one transfer request from its user and runs the break handshake.
 assumes the computer end answers with address, data accepted or ready pulses.
*/
`timescale 1ns/1ps
module csb_device
	import csb_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	csb_if.device LINK,
	input wire logic REQ_VALID,
	input wire logic REQ_INTO_MEMORY,
	input wire logic [14:0] REQ_ADDRESS,
	input wire logic [17:0] REQ_DATA,
	output logic REQ_READY,
	output logic DONE,
	output logic [17:0] READ_DATA
);
	csb_hs_t state_r;
	logic into_r;
	// ----------------------------------------
	// handshake
	// ----------------------------------------
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			state_r <= CSB_HS_IDLE;
		else
		begin
			case (state_r)
				CSB_HS_IDLE: if (REQ_VALID) state_r <= CSB_HS_WAIT;
				CSB_HS_WAIT: if (LINK.data_accepted_pulse || LINK.data_ready_pulse)
					state_r <= CSB_HS_DONE;
				CSB_HS_DONE: state_r <= CSB_HS_IDLE;
				default: state_r <= CSB_HS_IDLE;
			endcase
		end
	end
	// request, address, direction and data held from request to acknowledge
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			LINK.transfer_request_level <= 1'b0;
			LINK.dir_into_memory <= 1'b0;
			LINK.break_address_lines <= CSB_ADDR_RST;
			LINK.inbound_data_lines <= CSB_DATA_RST;
			into_r <= 1'b0;
		end
		else if (state_r == CSB_HS_IDLE && REQ_VALID)
		begin
			LINK.transfer_request_level <= 1'b1;
			LINK.dir_into_memory <= REQ_INTO_MEMORY;
			LINK.break_address_lines <= REQ_ADDRESS;
			LINK.inbound_data_lines <= REQ_DATA;
			into_r <= REQ_INTO_MEMORY;
		end
		else if (LINK.address_accepted_pulse)
			LINK.transfer_request_level <= 1'b0;
	end
	// data ready is sampled at once, long before the next T2
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			READ_DATA <= CSB_DATA_RST;
			DONE <= 1'b0;
			REQ_READY <= 1'b0;
		end
		else
		begin
			if (LINK.data_ready_pulse && !into_r)
				READ_DATA <= LINK.buffered_memory_out;
			DONE <= (state_r == CSB_HS_WAIT) &&
				(LINK.data_accepted_pulse || LINK.data_ready_pulse);
			REQ_READY <= (state_r == CSB_HS_IDLE) && !REQ_VALID;
		end
	end
endmodule // csb_device

//--- testbench/csb_assertions.sv
/*
 checker for the break channel link: pulse timing and order.
 assumes it watches the one link joining the computer and device ends.
*/
`timescale 1ns/1ps
module csb_assertions (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic transfer_request_level,
	input wire logic dir_into_memory,
	input wire logic address_accepted_pulse,
	input wire logic data_accepted_pulse,
	input wire logic data_ready_pulse,
	input wire logic [17:0] buffered_memory_out
);
	// ------------------------------
	// link timing
	// ------------------------------
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// a break cycle is 20 clocks, so a second ack this soon means a stuck pulse
	a_addr_single: assert property (address_accepted_pulse |=> !address_accepted_pulse [*8])
		else $error("address ack repeated too soon");
	a_acc_at_t3: assert property (address_accepted_pulse && dir_into_memory |-> ##8 data_accepted_pulse)
		else $error("data accepted missing at T3");
	a_rdy_at_t3: assert property (address_accepted_pulse && !dir_into_memory |-> ##8 data_ready_pulse)
		else $error("data ready missing at T3");
	a_acc_inward_only: assert property (data_accepted_pulse |-> dir_into_memory && $past(address_accepted_pulse, 8))
		else $error("data accepted outside inward break");
	a_rdy_outward_only: assert property (data_ready_pulse |-> !dir_into_memory && $past(address_accepted_pulse, 8))
		else $error("data ready outside outward break");
	a_addr_after_req: assert property ($rose(address_accepted_pulse) |-> $past(transfer_request_level))
		else $error("address ack without request");
	a_req_withdrawn: assert property (address_accepted_pulse |-> ##[1:2] !transfer_request_level)
		else $error("request kept after ack");
	a_out_word_held: assert property (data_ready_pulse |-> $stable(buffered_memory_out))
		else $error("output word moving at data ready");
endmodule // csb_assertions

//--- testbench/tb_cycle_steal_break_channel.sv
/*
 testbench: both ends joined by one link; writes words into core, reads them back.
 assumes the package constants and the device end's one-transfer-at-a-time handshake.
*/
`timescale 1ns/1ps
module tb_cycle_steal_break_channel
	import csb_pkg::*;
;
	// ------------------------------
	// harness
	// ------------------------------
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic req_valid = 1'b0;
	logic req_into = 1'b0;
	logic [14:0] req_addr = 15'h0000;
	logic [17:0] req_data = 18'h00000;
	logic req_ready, done, break_active;
	logic [17:0] read_data;
	logic [14:0] last_address;
	logic [14:0] ta [3] = '{15'h0000, 15'h7fff, 15'h2aaa};
	logic [17:0] td [3] = '{18'h3ffff, 18'h00001, 18'h2aaaa};
	int err_count = 0;
	int cmp_count = 0;
	csb_if link();
	csb_computer i_csb_computer (.CLK(clk), .RST_B(rst_b), .LINK(link),
		.BREAK_ACTIVE(break_active), .LAST_ADDRESS(last_address));
	csb_device i_csb_device (.CLK(clk), .RST_B(rst_b), .LINK(link), .REQ_VALID(req_valid),
		.REQ_INTO_MEMORY(req_into), .REQ_ADDRESS(req_addr), .REQ_DATA(req_data),
		.REQ_READY(req_ready), .DONE(done), .READ_DATA(read_data));
	csb_assertions i_csb_assertions (.CLK(clk), .RST_B(rst_b),
		.transfer_request_level(link.transfer_request_level),
		.dir_into_memory(link.dir_into_memory),
		.address_accepted_pulse(link.address_accepted_pulse),
		.data_accepted_pulse(link.data_accepted_pulse),
		.data_ready_pulse(link.data_ready_pulse),
		.buffered_memory_out(link.buffered_memory_out));
	initial forever #10 clk = ~clk;
	task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one transfer; the wait is bounded since break waits for the instruction end
	task automatic xfer(input logic into, input logic [14:0] a, input logic [17:0] d,
		input logic [17:0] exp);
		int n;
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		#1;
		chk("idle break", 18'h0, {17'h0, break_active});
		chk("request ready", 18'h1, {17'h0, req_ready});
		@(posedge clk);
		req_valid <= 1'b1;
		req_into <= into;
		req_addr <= a;
		req_data <= d;
		@(posedge clk);
		req_valid <= 1'b0;
		for (n = 0; n < 200 && done !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
			if (link.address_accepted_pulse === 1'b1)
			begin
				seen = 1'b1;
				chk("address lines", {3'h0, a}, {3'h0, link.break_address_lines});
				chk("direction", {17'h0, into}, {17'h0, link.dir_into_memory});
				chk("inbound lines", d, link.inbound_data_lines);
				chk("break level", 18'h1, {17'h0, break_active});
			end
		end
		if (done !== 1'b1)
		begin
			err_count++;
			summarize();
		end
		chk("ack seen", 18'h1, {17'h0, seen});
		chk("last address", {3'h0, a}, {3'h0, last_address});
		if (!into)
			chk("read data", exp, read_data);
		// the break cycle runs on to its end before the next request
		for (n = 0; n < 24 && break_active !== 1'b0; n++)
		begin
			@(posedge clk);
			#1;
		end
		chk("break ends", 18'h0, {17'h0, break_active});
	endtask
	// ------------------------------
	// tests
	// ------------------------------
	initial
	begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 3; i++)
			xfer(1'b1, ta[i], td[i], 18'h0);
		$display("test write done");
		// inbound lines carry a decoy while reading: it must not reach core
		for (int i = 0; i < 3; i++)
			xfer(1'b0, ta[i], 18'h15555, td[i]);
		$display("test read done");
		xfer(1'b1, 15'h7fff, 18'h00000, 18'h0);
		xfer(1'b0, 15'h7fff, 18'h3ffff, 18'h00000);
		xfer(1'b0, 15'h0000, 18'h00000, 18'h3ffff);
		$display("test overwrite done");
		summarize();
	end
endmodule // tb_cycle_steal_break_channel
